// *** core/slcr_regs.sv ***
// Summary of operation
// - routed status reports two-bit link source kind of each link
// - eight-bit destination link number readable while link in use
// - four-bit writable direction field per routed link, reset zero
// - two-bit writable network field per link, reset zero
// - read-only junk bit while current packet is being discarded
// - read-only busy bits for destination side and source side
// - eight processor link registers, no direction, bits 15:6 reserved
// - routed link registers serve links 0 to 7 from index 0x20
// - top bit enables external link and steers pin multiplexing
// - mode bit selects two-wire at 0, five-wire at 1
// - error flag on receive overflow or illegal token encoding
// - read-only bit shows this end issued credit to remote
// - read-only bit shows this end holds credit to transmit
// - credit-reset write clears own credit and sends credit request token
// - receiver-reset write makes next symbol the first of a token
// - symbol gap field gives minimum idle clocks minus one
// - token gap field gives minimum idle clocks between tokens minus one
// - external link registers serve links 0 to 7 from index 0x80
// - static enable forwards all traffic to set channel end
// - static mode picks processor bit and five-bit channel end
// - static registers map in order to links c,d,a,b,g,h,e,f
// - route dimension is most significant mismatching node id bit
//
// Added by the designer: the AHB-Lite interface to the registers.
module slcr_regs
	import slcr_pkg::*;
#(
	parameter int NODE_W = 16,
	parameter int DIM_W  = 4
) (
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic                    hready,
	input  wire logic [31:0]             hwdata,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire slcr_link_stat_t         routed_stat [NUM_LINKS],
	input  wire slcr_link_stat_t         proc_stat   [NUM_LINKS],
	output logic [3:0]                   routed_dir  [NUM_LINKS],
	output logic [1:0]                   routed_net  [NUM_LINKS],
	output logic [1:0]                   proc_net    [NUM_LINKS],
	input  wire logic [NUM_LINKS-1:0]    rx_overflow,
	input  wire logic [NUM_LINKS-1:0]    rx_bad_token,
	input  wire logic [NUM_LINKS-1:0]    credit_in,
	input  wire logic [NUM_LINKS-1:0]    rx_space,
	input  wire logic [NUM_LINKS-1:0]    sym_sent,
	input  wire logic [NUM_LINKS-1:0]    tok_done,
	output slcr_ext_cfg_t                ext_cfg     [NUM_LINKS],
	output logic [NUM_LINKS-1:0]         credit_grant,
	output logic [NUM_LINKS-1:0]         credit_req_send,
	output logic [NUM_LINKS-1:0]         rx_reset,
	output logic [NUM_LINKS-1:0]         tx_ready,
	output slcr_static_cfg_t             static_cfg  [NUM_LINKS],
	input  wire logic                    route_req,
	input  wire logic [NODE_W-1:0]       route_dest,
	input  wire logic [NODE_W-1:0]       node_id,
	output logic                         route_done,
	output logic                         route_miss,
	output logic [DIM_W-1:0]             route_dim
);

	// bus phase tracking
	logic        wr_pend_reg;
	logic [7:0]  wr_idx_reg;
	logic        ready_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  rd_idx_reg;

	// address phase decode
	wire        accept   = hsel & hready & htrans[1];
	wire        rd_start = accept & ~hwrite;
	wire        wr_start = accept & hwrite;
	wire [7:0]  addr_idx = haddr[9:2];
	wire        in_range = (haddr[31:10] == 22'h000000);

	// data phase write decode by group
	wire        wr_routed = wr_pend_reg & (wr_idx_reg[7:3] == IDX_ROUTED[7:3]);
	wire        wr_proc   = wr_pend_reg & (wr_idx_reg[7:3] == IDX_PROC[7:3]);
	wire        wr_ext    = wr_pend_reg & (wr_idx_reg[7:3] == IDX_EXT[7:3]);
	wire        wr_static = wr_pend_reg & (wr_idx_reg[7:3] == IDX_STATIC[7:3]);
	wire [2:0]  wr_link   = wr_idx_reg[2:0];

	// write data fields shared by every link
	wire             wd_en      = hwdata[EX_EN_BIT];
	wire             wd_five    = hwdata[EX_FIVE_BIT];
	wire             wd_crrst   = hwdata[EX_CRRST_BIT];
	wire             wd_rxrst   = hwdata[EX_RXRST_BIT];
	wire [GAP_W-1:0] wd_sym     = hwdata[EX_SYM_LSB +: GAP_W];
	wire [GAP_W-1:0] wd_tok     = hwdata[EX_TOK_LSB +: GAP_W];
	wire [3:0]       wd_dir     = hwdata[LS_DIR_LSB +: 4];
	wire [1:0]       wd_net     = hwdata[LS_NET_LSB +: 2];
	wire             wd_st_en   = hwdata[ST_EN_BIT];
	wire             wd_st_proc = hwdata[ST_PROC_BIT];
	wire [4:0]       wd_st_chan = hwdata[ST_CHAN_LSB +: 5];

	// read decode by group, during the wait cycle
	wire        rd_routed = (rd_idx_reg[7:3] == IDX_ROUTED[7:3]);
	wire        rd_proc   = (rd_idx_reg[7:3] == IDX_PROC[7:3]);
	wire        rd_ext    = (rd_idx_reg[7:3] == IDX_EXT[7:3]);
	wire        rd_static = (rd_idx_reg[7:3] == IDX_STATIC[7:3]);
	wire [2:0]  rd_link   = rd_idx_reg[2:0];

	logic [31:0] routed_word [NUM_LINKS];
	logic [31:0] proc_word   [NUM_LINKS];
	logic [31:0] ext_word    [NUM_LINKS];
	logic [31:0] static_word [NUM_LINKS];
	slcr_static_cfg_t st_cfg [NUM_LINKS];

	// selected read word, unmapped reads zero
	wire [31:0] rd_word = rd_routed ? routed_word[rd_link] :
	                      rd_proc   ? proc_word[rd_link]   :
	                      rd_ext    ? ext_word[rd_link]    :
	                      rd_static ? static_word[rd_link] : 32'h00000000;

	// writes complete in their data phase, reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
			rd_idx_reg  <= 8'h00;
			ready_reg   <= 1'b1;
			rdata_reg   <= 32'h00000000;
		end else begin
			wr_pend_reg <= wr_start & in_range;
			if (accept) begin
				wr_idx_reg <= addr_idx;
				rd_idx_reg <= in_range ? addr_idx : 8'hff;
			end
			ready_reg <= ~rd_start;
			if (!ready_reg) begin
				rdata_reg <= rd_word;
			end
		end
	end

	assign hreadyout = ready_reg;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;

	genvar g;
	generate
		for (g = 0; g < NUM_LINKS; g++) begin : gen_link
			logic [3:0]       dir_reg;
			logic [1:0]       rnet_reg;
			logic [1:0]       pnet_reg;
			logic             en_reg;
			logic             five_reg;
			logic [GAP_W-1:0] sym_reg;
			logic [GAP_W-1:0] tok_reg;
			logic             err_reg;
			logic             issued_reg;
			logic             held_reg;
			logic             grant_reg;
			logic             credit_request_token_reg;
			logic             rxrst_reg;
			logic [GAP_W:0]   gap_cnt_reg;
			logic             txr_reg;
			logic             st_en_reg;
			logic             st_proc_reg;
			logic [4:0]       st_chan_reg;

			wire hit_r  = wr_routed & (wr_link == 3'(g));
			wire hit_p  = wr_proc & (wr_link == 3'(g));
			wire hit_e  = wr_ext & (wr_link == 3'(g));
			wire hit_s  = wr_static & (wr_link == 3'(g));
			wire crrst  = hit_e & wd_crrst;
			wire rxrst  = hit_e & wd_rxrst;
			wire en_nx  = hit_e ? wd_en : en_reg;
			wire err_ev = rx_overflow[g] | rx_bad_token[g];
			// credit goes out only with room to receive
			wire give   = en_reg & rx_space[g] & ~issued_reg;
			wire held_nx = credit_in[g] | (held_reg & ~crrst);
			wire [GAP_W:0] sym_ld = {1'b0, sym_reg} + 12'h001;
			wire [GAP_W:0] tok_ld = {1'b0, tok_reg} + 12'h001;
			// idle count after each symbol or token
			wire [GAP_W:0] gap_nx =
				(sym_sent[g] & tok_done[g]) ? tok_ld :
				sym_sent[g] ? sym_ld :
				(gap_cnt_reg != 12'h000) ? gap_cnt_reg - 12'h001 :
				12'h000;

			// routed and processor link control fields
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					dir_reg  <= DIR_RST;
					rnet_reg <= NET_RST;
					pnet_reg <= NET_RST;
				end else begin
					if (hit_r) begin
						dir_reg  <= wd_dir;
						rnet_reg <= wd_net;
					end
					if (hit_p) begin
						pnet_reg <= wd_net;
					end
				end
			end

			// external link setup fields
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					en_reg   <= 1'b0;
					five_reg <= 1'b0;
					sym_reg  <= GAP_RST;
					tok_reg  <= GAP_RST;
				end else if (hit_e) begin
					en_reg   <= wd_en;
					five_reg <= wd_five;
					sym_reg  <= wd_sym;
					tok_reg  <= wd_tok;
				end
			end

			// sticky error flag, an event wins over a clear
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					err_reg <= 1'b0;
				end else begin
					err_reg <= err_ev | (err_reg & ~rxrst);
				end
			end

			// credit state, incoming credit wins over a clear
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					issued_reg <= 1'b0;
					held_reg   <= 1'b0;
					grant_reg  <= 1'b0;
				end else begin
					issued_reg <= give |
						(issued_reg & ~rxrst & en_nx);
					held_reg   <= held_nx;
					grant_reg  <= give;
				end
			end

			// one-cycle command pulses towards the link core
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					credit_request_token_reg <= 1'b0;
					rxrst_reg <= 1'b0;
				end else begin
					credit_request_token_reg <= crrst;
					rxrst_reg <= rxrst;
				end
			end

			// transmit pacing, ready only with credit and no gap left
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					gap_cnt_reg <= 12'h000;
					txr_reg     <= 1'b0;
				end else begin
					gap_cnt_reg <= gap_nx;
					txr_reg     <= en_nx & held_nx &
						(gap_nx == 12'h000);
				end
			end

			// static forwarding setup
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					st_en_reg   <= 1'b0;
					st_proc_reg <= 1'b0;
					st_chan_reg <= CHAN_RST;
				end else if (hit_s) begin
					st_en_reg   <= wd_st_en;
					st_proc_reg <= wd_st_proc;
					st_chan_reg <= wd_st_chan;
				end
			end

			// read words per link
			assign routed_word[g] = {
				6'h00,
				routed_stat[g].link_source_kind,
				routed_stat[g].dest_link,
				4'h0,
				dir_reg,
				2'h0,
				rnet_reg,
				1'b0,
				routed_stat[g].junk,
				routed_stat[g].dst_busy,
				routed_stat[g].src_busy};
			assign proc_word[g] = {
				6'h00,
				proc_stat[g].link_source_kind,
				proc_stat[g].dest_link,
				10'h000,
				pnet_reg,
				1'b0,
				proc_stat[g].junk,
				proc_stat[g].dst_busy,
				proc_stat[g].src_busy};
			assign ext_word[g] = {
				en_reg,
				five_reg,
				2'h0,
				err_reg,
				issued_reg,
				held_reg,
				2'h0,
				1'b0,
				sym_reg,
				tok_reg};
			assign static_word[g] = {
				st_en_reg,
				22'h000000,
				st_proc_reg,
				3'h0,
				st_chan_reg};

			// static setup of this register, reordered by letter below
			assign st_cfg[g] = '{st_en_reg, st_proc_reg, st_chan_reg};

			// outputs to the switch and link cores
			assign routed_dir[g]      = dir_reg;
			assign routed_net[g]      = rnet_reg;
			assign proc_net[g]        = pnet_reg;
			assign ext_cfg[g]         = '{en_reg, five_reg, sym_reg, tok_reg};
			assign credit_grant[g]    = grant_reg;
			assign credit_req_send[g] = credit_request_token_reg;
			assign rx_reset[g]        = rxrst_reg;
			assign tx_ready[g]        = txr_reg;
		end

		// letter order of the static registers
		for (g = 0; g < NUM_LINKS; g++) begin : gen_static_map
			assign static_cfg[g] = st_cfg[STATIC_SRC[g]];
		end
	endgenerate

	// most significant mismatching bit of two node ids
	function automatic logic [DIM_W-1:0] msb_mismatch(
		input logic [NODE_W-1:0] diff
	);
		logic [DIM_W-1:0] pos;
		pos = '0;
		for (int i = 0; i < NODE_W; i++) begin
			if (diff[i]) begin
				pos = DIM_W'(i);
			end
		end
		return pos;
	endfunction

	logic             route_done_reg;
	logic             route_miss_reg;
	logic [DIM_W-1:0] route_dim_reg;
	wire [NODE_W-1:0] route_diff = route_dest ^ node_id;

	// routing dimension lookup, one cycle per request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			route_done_reg <= 1'b0;
			route_miss_reg <= 1'b0;
			route_dim_reg  <= '0;
		end else begin
			route_done_reg <= route_req;
			if (route_req) begin
				route_miss_reg <= |route_diff;
				route_dim_reg  <= msb_mismatch(route_diff);
			end
		end
	end

	assign route_done = route_done_reg;
	assign route_miss = route_miss_reg;
	assign route_dim  = route_dim_reg;

endmodule

// *** core/slcr_pkg.sv ***
package slcr_pkg;
	localparam int NUM_LINKS = 8;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_ROUTED = 8'h20;
	localparam logic [7:0] IDX_PROC   = 8'h40;
	localparam logic [7:0] IDX_EXT    = 8'h80;
	localparam logic [7:0] IDX_STATIC = 8'ha0;
	// routed and processor link fields
	localparam int LS_KIND_LSB = 24;
	localparam int LS_DEST_LSB = 16;
	localparam int LS_DIR_LSB  = 8;
	localparam int LS_NET_LSB  = 4;
	localparam int LS_JUNK_BIT = 2;
	localparam int LS_DST_BIT  = 1;
	localparam int LS_SRC_BIT  = 0;
	// external link fields
	localparam int EX_EN_BIT     = 31;
	localparam int EX_FIVE_BIT   = 30;
	localparam int EX_ERR_BIT    = 27;
	localparam int EX_ISSUED_BIT = 26;
	localparam int EX_HELD_BIT   = 25;
	localparam int EX_CRRST_BIT  = 24;
	localparam int EX_RXRST_BIT  = 23;
	localparam int EX_SYM_LSB    = 11;
	localparam int EX_TOK_LSB    = 0;
	localparam int GAP_W         = 11;
	// static forwarding fields
	localparam int ST_EN_BIT   = 31;
	localparam int ST_PROC_BIT = 8;
	localparam int ST_CHAN_LSB = 0;
	// reset values
	localparam logic [3:0]       DIR_RST  = 4'h0;
	localparam logic [1:0]       NET_RST  = 2'h0;
	localparam logic [GAP_W-1:0] GAP_RST  = 11'h000;
	localparam logic [4:0]       CHAN_RST = 5'h00;
	// static register index feeding each link letter a..h
	localparam int STATIC_SRC [NUM_LINKS] = '{2, 3, 0, 1, 6, 7, 4, 5};

	typedef enum logic [1:0] {
		SLCR_SWITCH_LINK    = 2'h0,
		SLCR_PROCESSOR_LINK = 2'h1,
		SLCR_SWITCH_CONTROL = 2'h2,
		SLCR_UNDEFINED      = 2'h3
	} slcr_link_source_kind_t;

	typedef struct packed {
		logic [1:0] link_source_kind;
		logic [7:0] dest_link;
		logic       junk;
		logic       dst_busy;
		logic       src_busy;
	} slcr_link_stat_t;

	typedef struct packed {
		logic             enable;
		logic             five_wire;
		logic [GAP_W-1:0] sym_gap;
		logic [GAP_W-1:0] tok_gap;
	} slcr_ext_cfg_t;

	typedef struct packed {
		logic       enable;
		logic       proc;
		logic [4:0] chanend;
	} slcr_static_cfg_t;
endpackage

// *** tb/slcr_regs_monitor.sv ***
module slcr_regs_monitor
	import slcr_pkg::*;
(
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic                 hready,
	input wire logic [31:0]          hwdata,
	input wire logic                 hreadyout,
	input wire logic [NUM_LINKS-1:0] rx_space,
	input wire logic [NUM_LINKS-1:0] sym_sent,
	input wire logic [NUM_LINKS-1:0] credit_grant,
	input wire logic [NUM_LINKS-1:0] credit_req_send,
	input wire logic [NUM_LINKS-1:0] rx_reset,
	input wire logic [NUM_LINKS-1:0] tx_ready,
	input wire slcr_ext_cfg_t        ext_cfg [NUM_LINKS],
	input wire logic                 route_req,
	input wire logic                 route_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        wr_q;
	logic [31:0] a_q;
	logic [2:0]  ai;
	logic        take;
	logic        ext_wr;
	// request decode and write data phase towards an external link word
	assign take = hsel && hready && htrans[1];
	assign ai = a_q[4:2];
	assign ext_wr = wr_q && hready && a_q[31:5] == 27'h10;
	// remember the address phase of each accepted write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			a_q <= 32'h0;
		end else if (hready) begin
			wr_q <= take && hwrite;
			a_q <= haddr;
		end
	end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_rd;
		take && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd: assert property (p_rd) else $error("read wait state wrong");
	property p_wr;
		take && hwrite |=> hreadyout;
	endproperty
	a_wr: assert property (p_wr) else $error("write stalled");
	property p_crq;
		ext_wr && hwdata[24] |=> credit_req_send[$past(ai)];
	endproperty
	a_crq: assert property (p_crq) else $error("no credit request");
	property p_rxr;
		ext_wr && hwdata[23] |=> rx_reset[$past(ai)] ##1 !rx_reset[$past(ai, 2)];
	endproperty
	a_rxr: assert property (p_rxr) else $error("receiver reset wrong");
	property p_gap;
		sym_sent[0] |=> !tx_ready[0];
	endproperty
	a_gap: assert property (p_gap) else $error("no idle gap");
	property p_txen;
		tx_ready[0] |-> ext_cfg[0].enable;
	endproperty
	a_txen: assert property (p_txen) else $error("ready while off");
	property p_grant;
		$rose(credit_grant[0]) |-> $past(rx_space[0]);
	endproperty
	a_grant: assert property (p_grant) else $error("credit w/o space");
	property p_route;
		route_req |=> route_done ##1 !route_done;
	endproperty
	a_route: assert property (p_route) else $error("route answer late");
	c_grant: cover property (credit_grant[0]);
	c_rxr: cover property (rx_reset != 8'h00);
	c_route: cover property (route_done);
endmodule

bind slcr_regs slcr_regs_monitor i_mon (.*);

// *** tb/slcr_peer.sv ***
module slcr_peer
	import slcr_pkg::*;
(
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic [NUM_LINKS-1:0] credit_req_send,
	input wire logic                 space,
	input wire logic [3:0]           lag,
	output logic [NUM_LINKS-1:0]     credit_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NUM_LINKS-1:0] pend;
	logic [3:0]           cnt;
	// answer credit requests after a lag, only with buffer space
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= 8'h00;
			cnt <= 4'h0;
			credit_in <= 8'h00;
		end else begin
			credit_in <= 8'h00;
			if (|credit_req_send) begin
				pend <= pend | credit_req_send;
				cnt <= lag;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (space && |pend) begin
				credit_in <= pend;
				pend <= 8'h00;
			end
		end
	end
endmodule

// *** tb/switch_link_control_regs_tb_top.sv ***
module switch_link_control_regs_tb_top
	import slcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel = 1'b1;
	logic             hwrite = 1'b0;
	logic             route_req = 1'b0;
	logic             space = 1'b0;
	logic [1:0]       htrans = 2'h0;
	logic [2:0]       hsize = 3'h2;
	logic [31:0]      haddr = 32'h0;
	logic [31:0]      hwdata = 32'h0;
	logic [15:0]      route_dest = 16'h0;
	logic [15:0]      node_id = 16'h0;
	logic [7:0]       rx_overflow = 8'h00;
	logic [7:0]       rx_bad_token = 8'h00;
	logic [7:0]       rx_space = 8'h00;
	logic [7:0]       sym_sent = 8'h00;
	logic [7:0]       tok_done = 8'h00;
	logic [7:0]       credit_in, credit_grant, credit_req_send;
	logic [7:0]       rx_reset, tx_ready;
	logic             hready, hreadyout, hresp, route_done, route_miss;
	logic [31:0]      hrdata, d, q, r;
	logic [3:0]       route_dim;
	slcr_link_stat_t  routed_stat [NUM_LINKS];
	slcr_link_stat_t  proc_stat [NUM_LINKS];
	logic [3:0]       routed_dir [NUM_LINKS];
	logic [1:0]       routed_net [NUM_LINKS];
	logic [1:0]       proc_net [NUM_LINKS];
	slcr_ext_cfg_t    ext_cfg [NUM_LINKS];
	slcr_static_cfg_t static_cfg [NUM_LINKS];
	int               i, k, n, cyc, mismatches, samples_checked;
	int               seed = 54996;
	int               lmap [8] = '{2, 3, 0, 1, 6, 7, 4, 5};
	assign hready = hreadyout;
	slcr_regs i_dut (.*);
	slcr_peer i_peer (.hclk, .hresetn, .credit_req_send, .space,
		.lag(4'h5), .credit_in);
	// system clock and hang guard
	initial begin
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic summarize();
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// one single word transfer, held until the slave is ready
	task automatic xf(input logic w, input logic [31:0] a, v,
		output logic [31:0] o);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		o = hrdata;
	endtask
	function automatic logic [31:0] ba(input logic [7:0] x);
		return {22'h0, x, 2'h0};
	endfunction
	function automatic logic [31:0] stw(input slcr_link_stat_t s,
		input logic [3:0] dr, input logic [1:0] nt);
		return {6'h0, s.link_source_kind, s.dest_link, 4'h0, dr, 2'h0,
			nt, 1'b0, s.junk, s.dst_busy, s.src_busy};
	endfunction
	function automatic logic [3:0] msb(input logic [15:0] x);
		msb = 4'h0;
		for (int b = 0; b < 16; b++)
			if (x[b]) msb = 4'(b);
	endfunction
	// register groups, reset values, then live traffic
	initial begin
		for (i = 0; i < NUM_LINKS; i++) begin
			r = $random(seed);
			routed_stat[i] <= {2'(i), r[10:0]};
			proc_stat[i] <= r[28:16];
		end
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < NUM_LINKS; i++) begin
			d = $random(seed);
			xf(0, ba(IDX_ROUTED + 8'(i)), 0, q);
			chk(q, stw(routed_stat[i], 4'h0, 2'h0));
			xf(1, ba(IDX_ROUTED + 8'(i)), d, q);
			xf(0, ba(IDX_ROUTED + 8'(i)), 0, q);
			chk(q, stw(routed_stat[i], d[11:8], d[5:4]));
			chk({routed_dir[i], routed_net[i]}, {d[11:8], d[5:4]});
			xf(1, ba(IDX_PROC + 8'(i)), d, q);
			xf(0, ba(IDX_PROC + 8'(i)), 0, q);
			chk(q, stw(proc_stat[i], 4'h0, d[5:4]));
			chk(proc_net[i], d[5:4]);
			xf(0, ba(IDX_EXT + 8'(i)), 0, q);
			chk(q, 0);
			xf(1, ba(IDX_EXT + 8'(i)), d, q);
			xf(0, ba(IDX_EXT + 8'(i)), 0, q);
			chk(q, d & 32'hc03fffff);
			chk(ext_cfg[i], {d[31:30], d[21:0]});
			xf(0, ba(IDX_STATIC + 8'(i)), 0, q);
			chk(q, 0);
			xf(1, ba(IDX_STATIC + 8'(i)), d, q);
			xf(0, ba(IDX_STATIC + 8'(i)), 0, q);
			chk(q, d & 32'h8000011f);
			chk(static_cfg[lmap[i]], {d[31], d[8], d[4:0]});
		end
		xf(1, 32'h400, 32'hffffffff, q);
		xf(0, 32'h400, 0, q);
		chk(q, 0);
		chk(hresp, 0);
		xf(0, ba(IDX_ROUTED + 8'h08), 0, q);
		chk(q, 0);
		space <= 1'b1;
		xf(1, ba(IDX_EXT), 32'h81000000, q);
		repeat (10) @(posedge hclk);
		xf(0, ba(IDX_EXT), 0, q);
		chk(q, 32'h82000000);
		rx_space <= 8'h01;
		repeat (4) @(posedge hclk);
		xf(0, ba(IDX_EXT), 0, q);
		chk(q, 32'h86000000);
		chk(tx_ready[0], 1);
		xf(1, ba(IDX_EXT), 32'h80001004, q);
		for (k = 0; k < 2; k++) begin
			@(posedge hclk);
			sym_sent <= 8'h01;
			tok_done <= 8'(k);
			@(posedge hclk);
			sym_sent <= 8'h00;
			tok_done <= 8'h00;
			for (n = 0; n < 60; n++) begin
				@(posedge hclk);
				if (tx_ready[0]) break;
			end
			chk((n >= 3 + 2 * k) && (n < 60), 1);
			@(posedge hclk);
			if (k == 1) rx_bad_token <= 8'h02;
			else rx_overflow <= 8'h02;
			@(posedge hclk);
			rx_bad_token <= 8'h00;
			rx_overflow <= 8'h00;
			xf(0, ba(IDX_EXT + 8'h01), 0, q);
			chk(q[27], 1);
			xf(1, ba(IDX_EXT + 8'h01), 32'h00800000, q);
			xf(0, ba(IDX_EXT + 8'h01), 0, q);
			chk(q[27], 0);
		end
		xf(1, ba(IDX_EXT), 32'h81000000, q);
		xf(0, ba(IDX_EXT), 0, q);
		chk(q, 32'h84000000);
		for (k = 0; k < 24; k++) begin
			d = (k == 0) ? 32'h00010000 : (k == 1) ? 32'h80000000
				: $random(seed);
			@(posedge hclk);
			route_dest <= d[15:0];
			node_id <= d[31:16];
			route_req <= 1'b1;
			@(posedge hclk);
			route_req <= 1'b0;
			@(posedge hclk);
			chk(route_done, 1);
			chk(route_dim, msb(d[15:0] ^ d[31:16]));
			chk(route_miss, |(d[15:0] ^ d[31:16]));
		end
		summarize();
	end
endmodule
